// file: host_port_consts.svh
// constants for the fifo ready flag host port
`ifndef HOST_PORT_CONSTS_SVH
`define HOST_PORT_CONSTS_SVH
`define CTRL_TYPE_BIT     4
`define CTRL_POL_BIT      5
`define CTRL_DIR_BIT      6
`define CTRL_THRESHOLD_SELECT_LO_BIT    2
`define CTRL_THRESHOLD_SELECT_HI_BIT    3
`define CTRL_WIDTH        10
`define CTRL1_RESET       10'h030
`define CTRL0_RESET       10'h000
`define FIFO_DEPTH        16
`define CNT_WIDTH         5
`define REG_SEL_BIT       9
`endif

// file: host_port_pkg.sv
// types for the fifo ready flag host port
package host_port_pkg;
    typedef enum logic {
        flag_level,
        flag_pulse
    } flag_form_t;
    typedef enum logic [1:0] {
        st_idle,
        st_active,
        st_wait_reads
    } flag_state_t;
endpackage

// file: strobe_decode.sv
// internal read and write strobe decoder with pin synchronisers
`timescale 1ns/100ps
module strobe_decode (
    input  wire logic clk,                    // system clock
    input  wire logic rst,                    // synchronous reset
    input  wire logic direction_mode,         // 1: write pin is direction line
    input  wire logic chip_select_active_low, // pin, active low select
    input  wire logic chip_select_active_high,// pin, active high select
    input  wire logic read_n,                 // pin, read strobe active low
    input  wire logic write_n,                // pin, write strobe or direction
    output logic      read_strobe,            // internal read strobe level
    output logic      write_strobe,           // internal write strobe level
    output logic      read_fall,              // pulse, read strobe began
    output logic      write_end               // pulse, write strobe ended
);
    logic [3:0] meta;
    logic [3:0] sync;
    logic       read_q;
    logic       write_q;
    wire        cs_ok;
    wire        rd_req;
    wire        wr_req;

    always_ff @(posedge clk) begin
        if (rst) begin
            meta    <= 4'h0;
            sync    <= 4'hf;
            read_q  <= 1'b0;
            write_q <= 1'b0;
        end else begin
            meta    <= {chip_select_active_low, chip_select_active_high, read_n, write_n};
            sync    <= meta;
            read_q  <= read_strobe;
            write_q <= write_strobe;
        end
    end

    // access starts when the last of selects and strobe becomes valid
    assign cs_ok  = !sync[3] && sync[2];
    // direction mode: write pin high reads, low writes; read pin ignored
    assign rd_req = direction_mode ? sync[0] : !sync[1];
    assign wr_req = direction_mode ? !sync[0] : !sync[0];
    assign read_strobe  = cs_ok && rd_req && (direction_mode || sync[0]);
    assign write_strobe = cs_ok && wr_req && (direction_mode || sync[1]);
    assign read_fall = read_strobe && !read_q;
    assign write_end = write_q && !write_strobe;
endmodule

// file: fifo_ready_flag_host_port.sv
// fifo ready flag generator and host strobe logic
// ==========================================================
// Functional notes
// - bit 4 selects level or pulse flag
// - bit 5 selects flag polarity, 1 high
// - flag asserts when stored words reach threshold
// - flag deasserts in both level and pulse
// - level flag drops at first read strobe
// - level retriggers only after threshold reads
// - continuous mode pulse: half conversion clock
// - single mode pulse: half oscillator cycle
// - next pulse waits for threshold reads
// - bit 6 clear: read pin strobes reads
// - access begins when last select/strobe valid
// - threshold from select bits and channel count
// - bit 6 makes write pin a direction line
// - read strobe pops fifo, enables output buffers
// - write strobe latches control words
`timescale 1ns/100ps
`include "host_port_consts.svh"
module fifo_ready_flag_host_port
    import host_port_pkg::*;
#(
    parameter int DEPTH = `FIFO_DEPTH,
    parameter int CW    = `CNT_WIDTH
) (
    input  wire logic          clk,                     // system clock, 25 MHz
    input  wire logic          rst,                     // synchronous reset, active high
    input  wire logic          chip_select_active_low,  // select pin
    input  wire logic          chip_select_active_high, // select pin
    input  wire logic          read_n,                  // read strobe pin
    input  wire logic          write_n,                 // write strobe or direction pin
    input  wire logic [9:0]    data_in,                 // control word from host bus
    input  wire logic [CW-1:0] fifo_count,              // stored fifo words
    input  wire logic [2:0]    active_channels,         // 1..4 channels
    input  wire logic          continuous_mode,         // 1 continuous, 0 single conversion
    input  wire logic          external_conversion_clock, // conversion clock pin
    input  wire logic          oscillator_clock,        // internal oscillator level
    output logic               fifo_pop,                // pulse, pop one fifo word
    output logic               output_enable,           // data bus output enable
    output logic               words_ready_flag,        // availability output
    output logic [9:0]         control0,                // control register 0
    output logic [9:0]         control1,                // control register 1
    output logic [4:0]         trigger_threshold        // current threshold, 0 reserved
);
    // ==========================================================
    // strobes
    logic        read_strobe;
    logic        write_strobe;
    logic        read_fall;
    logic        write_end;
    logic [9:0]  wr_data;
    logic [9:0]  data_meta;
    logic [9:0]  data_sync;

    strobe_decode u_dec (
        .clk                     (clk),
        .rst                     (rst),
        .direction_mode          (control1[`CTRL_DIR_BIT]),
        .chip_select_active_low  (chip_select_active_low),
        .chip_select_active_high (chip_select_active_high),
        .read_n                  (read_n),
        .write_n                 (write_n),
        .read_strobe             (read_strobe),
        .write_strobe            (write_strobe),
        .read_fall               (read_fall),
        .write_end               (write_end)
    );

    assign fifo_pop      = read_fall;
    assign output_enable = read_strobe;

    // data pins pass the same two stages as the strobes, so both stay aligned;
    // data is captured while the strobe is held so the latch at its end sees stable bits
    always_ff @(posedge clk) begin
        if (rst) begin
            data_meta <= 10'h000;
            data_sync <= 10'h000;
            wr_data   <= 10'h000;
            control0  <= `CTRL0_RESET;
            control1  <= `CTRL1_RESET;
        end else begin
            data_meta <= data_in;
            data_sync <= data_meta;
            if (write_strobe) begin
                wr_data <= data_sync;
            end
            if (write_end) begin
                if (wr_data[`REG_SEL_BIT]) begin
                    control1 <= wr_data;
                end else begin
                    control0 <= wr_data;
                end
            end
        end
    end

    // ==========================================================
    // threshold table
    function automatic logic [4:0] threshold_of(input logic [1:0] sel, input logic [2:0] ch);
        logic [4:0] t;
        t = 5'h00;
        unique case (sel)
            2'b00: t = {2'b00, ch};
            2'b01: t = (ch == 3'h4) ? 5'h08 : (ch == 3'h3) ? 5'h06 : 5'h04;
            2'b10: t = (ch == 3'h4) ? 5'h0c : (ch == 3'h3) ? 5'h09 : 5'h08;
            2'b11: t = (ch == 3'h4) ? 5'h00 : (ch == 3'h1) ? 5'h0e : 5'h0c;
        endcase
        return t;
    endfunction

    // reserved code yields zero threshold, which never triggers
    assign trigger_threshold = threshold_of({control1[`CTRL_THRESHOLD_SELECT_HI_BIT],
                                             control1[`CTRL_THRESHOLD_SELECT_LO_BIT]},
                                            active_channels);

    // ==========================================================
    // pulse timing clock
    logic [1:0] conv_sync;
    logic [1:0] osc_sync;
    logic       pclk_q;
    wire        pclk;
    wire        pclk_edge;

    always_ff @(posedge clk) begin
        if (rst) begin
            conv_sync <= 2'b00;
            osc_sync  <= 2'b00;
            pclk_q    <= 1'b0;
        end else begin
            conv_sync <= {conv_sync[0], external_conversion_clock};
            osc_sync  <= {osc_sync[0], oscillator_clock};
            pclk_q    <= pclk;
        end
    end

    // pulse width follows whichever clock drives conversion
    assign pclk      = continuous_mode ? conv_sync[1] : osc_sync[1];
    assign pclk_edge = pclk != pclk_q;

    // ==========================================================
    // flag state machine
    flag_state_t state;
    flag_state_t next_state;
    logic [4:0]  reads;
    logic        active;
    wire         form_pulse;
    wire         reached;
    wire         reads_done;

    assign form_pulse = control1[`CTRL_TYPE_BIT];
    assign reached    = (trigger_threshold != 5'h00) &&
                        (5'(fifo_count) >= trigger_threshold);
    assign reads_done = reads >= trigger_threshold;

    always_comb begin
        next_state = state;
        unique case (state)
            st_idle: begin
                if (reached) begin
                    next_state = st_active;
                end
            end
            st_active: begin
                // level drops on first read, pulse at the next edge of the conversion clock (continuous) or oscillator clock (single)
                if (form_pulse ? pclk_edge : read_fall) begin
                    next_state = st_wait_reads;
                end
            end
            st_wait_reads: begin
                if (reads_done) begin
                    next_state = st_idle;
                end
            end
            default: next_state = st_idle;
        endcase
    end

    always_ff @(posedge clk) begin
        if (rst) begin
            state <= st_idle;
            reads <= 5'h00;
        end else begin
            state <= next_state;
            if (state == st_idle && reached) begin
                reads <= 5'h00;
            end else if (read_fall && reads != 5'h1f) begin
                reads <= reads + 5'h01;
            end
        end
    end

    assign active = state == st_active;
    // polarity bit 1 means active high
    always_ff @(posedge clk) begin
        if (rst) begin
            words_ready_flag <= 1'b1;
        end else begin
            words_ready_flag <= control1[`CTRL_POL_BIT] ? active : !active;
        end
    end
endmodule

// file: host_bus_model.sv
// host processor model driving the select, strobe and data pins
`timescale 1ns/100ps
module host_bus_model (
    input  wire logic  clk,  // system clock
    output logic       cs_l, // select, active low
    output logic       cs_h, // select, active high
    output logic       rd_n, // read strobe
    output logic       wr_n, // write strobe or direction line
    output logic [9:0] data  // control word bus
);
    initial {cs_l, cs_h, rd_n, wr_n, data} = 14'h2fff;
    // ==========
    // bus access
    // strobe held 4 cycles and idle 4, since the pins pass 2 synchronising stages
    task automatic access(input logic dir, input logic wr, input logic [9:0] d);
        @(posedge clk);
        cs_l <= 1'b0;
        data <= d;
        rd_n <= dir | wr;
        wr_n <= ~wr;
        @(posedge clk);
        cs_h <= 1'b1;
        repeat (4) @(posedge clk);
        {cs_l, cs_h, rd_n, wr_n} <= 4'hb;
        repeat (4) @(posedge clk);
        data <= ~d;        // after the 4 idle cycles the released bus shows the inverted word
    endtask
endmodule

// file: fifo_ready_flag_host_port_chk.sv
// assertions on the ports of the fifo ready flag host port
`timescale 1ns/100ps
module fifo_ready_flag_host_port_chk #(
    parameter int CW = 5
) (
    input wire logic          clk,                     // clock
    input wire logic          rst,                     // reset
    input wire logic          chip_select_active_low,  // select pin
    input wire logic          chip_select_active_high, // select pin
    input wire logic [9:0]    data_in,                 // host word
    input wire logic [CW-1:0] fifo_count,              // stored words
    input wire logic [2:0]    active_channels,         // channel count
    input wire logic          fifo_pop,                // pop pulse
    input wire logic          output_enable,           // bus enable
    input wire logic          words_ready_flag,        // availability
    input wire logic [9:0]    control1,                // configuration
    input wire logic [4:0]    trigger_threshold        // threshold
);
    default clocking cb @(posedge clk); endclocking
    default disable iff (rst);
    wire act = (words_ready_flag == control1[5]);
    // ==========
    // assertions
    a_pop_single: assert property (fifo_pop |=> !fifo_pop)
        else $error("pop longer than one cycle");
    a_pop_enables: assert property (fifo_pop |-> output_enable)
        else $error("pop without output enable");
    a_oe_selected: assert property (output_enable |->
        $past(chip_select_active_high, 2) && !$past(chip_select_active_low, 2))
        else $error("output enabled while not selected");
    a_thr_base: assert property (control1[3:2] == 2'b00 && active_channels inside {[1:4]}
        |-> trigger_threshold == {2'b00, active_channels})
        else $error("lowest threshold wrong");
    a_flag_cause: assert property ($rose(act) && $stable(control1) |->
        $past(fifo_count, 2) >= $past(trigger_threshold, 2))
        else $error("flag raised below threshold");
    a_level_drop: assert property (!control1[4] && act && fifo_pop |-> ##[0:2] !act)
        else $error("level flag kept after read");
    a_pulse_short: assert property (control1[4] && $rose(act) |-> ##[1:10] !act)
        else $error("pulse too long");
    a_ctrl_load: assert property ($changed(control1) |->
        control1[6:2] == $past(data_in[6:2]))
        else $error("control word not from bus");
    c_pulse: cover property (control1[4] && $rose(act));
    c_dir_read: cover property (fifo_pop && control1[6]);
    c_level_drop: cover property ($fell(act) && !control1[4]);
endmodule
bind fifo_ready_flag_host_port fifo_ready_flag_host_port_chk #(.CW(CW)) i_chk (
    .clk, .rst, .chip_select_active_low, .chip_select_active_high, .data_in, .fifo_count,
    .active_channels, .fifo_pop, .output_enable, .words_ready_flag, .control1, .trigger_threshold
);

// file: fifo_ready_flag_host_port_test.sv
// self-checking bench for the fifo ready flag host port
`timescale 1ns/100ps
module fifo_ready_flag_host_port_test;
    logic       clk = 1'b0, rst = 1'b1, cont = 1'b1, conv = 1'b0, osc = 1'b0, dm = 1'b0;
    logic [4:0] cnt = 5'h00;
    logic [2:0] chans = 3'h1;
    wire        cs_l, cs_h, rd_n, wr_n, fifo_pop, flag, oe;
    wire  [9:0] data, control0, control1;
    wire  [4:0] thr;
    int         err_total = 0, n_checks = 0, pops = 0, p0, hi, oes = 0, o0;
    logic [4:0] thr_tab [16] = '{1, 2, 3, 4, 4, 4, 6, 8, 8, 8, 9, 12, 14, 12, 12, 0};
    always #20 clk = ~clk;
    always #160 conv = ~conv; // half cycle is 4 system cycles
    always #240 osc = ~osc;   // half cycle is 6 system cycles
    always @(posedge clk) if (fifo_pop === 1'b1) pops <= pops + 1;
    always @(posedge clk) if (oe === 1'b1) oes <= oes + 1;
    host_bus_model i_host (.clk, .cs_l, .cs_h, .rd_n, .wr_n, .data);
    fifo_ready_flag_host_port i_dut (
        .clk, .rst, .chip_select_active_low(cs_l), .chip_select_active_high(cs_h), .read_n(rd_n),
        .write_n(wr_n), .data_in(data), .fifo_count(cnt), .active_channels(chans),
        .continuous_mode(cont), .external_conversion_clock(conv), .oscillator_clock(osc),
        .fifo_pop, .output_enable(oe), .words_ready_flag(flag), .control0, .control1,
        .trigger_threshold(thr)
    );
    task automatic chk(input logic [9:0] got, input logic [9:0] exp);
        n_checks++;
        if (got !== exp) begin
            err_total++;
            $display("CHECK FAILED at %0t: got %h expected %h", $time, got, exp);
        end
    endtask
    task automatic restart();
        @(posedge clk) {rst, cnt} <= 6'h20;
        repeat (2) @(posedge clk);
        rst <= 1'b0;
        dm <= 1'b0;
        repeat (3) @(negedge clk);
    endtask
    task automatic acc(input logic wr, input logic [9:0] d, input int n);
        repeat (n) i_host.access(dm, wr, d);
        repeat (2) @(negedge clk);
    endtask
    task automatic wait_hi(input int n);
        hi = 0;
        repeat (n) @(negedge clk) hi += (flag === 1'b1);
    endtask
    task automatic tally_and_finish();
        $display("checks %0d mismatches %0d", n_checks, err_total);
        if (err_total == 0 && n_checks > 0)
            $display("Run complete: PASS");
        else
            $display("Run complete: FAIL");
        $finish;
    endtask
    initial begin
        #200000;
        err_total++;
        tally_and_finish();
    end
    initial begin
        restart();
        chk(control1, 10'h030);
        chk(control0, 10'h000);
        chk(10'(flag), 10'h000);
        for (int t = 0; t < 4; t++) begin
            acc(1'b1, 10'h200 | 10'(t << 2), 1);
            chk({1'b0, control1[8:0]}, 10'(t << 2));
            for (int c = 1; c < 5; c++) begin
                @(posedge clk) chans <= 3'(c);
                @(negedge clk);
                chk(10'(thr), 10'(thr_tab[t * 4 + c - 1]));
            end
        end
        $display("reset and threshold tests done");
        restart();
        @(posedge clk) chans <= 3'h1;
        acc(1'b1, 10'h224, 1);
        @(posedge clk) cnt <= 5'h03;
        wait_hi(6);
        chk(10'(hi), 10'h000);
        @(posedge clk) cnt <= 5'h04;
        repeat (3) @(negedge clk);
        chk(10'(flag), 10'h001);
        p0 = pops;
        acc(1'b0, 10'h155, 1);
        chk(10'(flag), 10'h000);
        acc(1'b0, 10'h155, 2);
        chk(10'(flag), 10'h000);
        acc(1'b0, 10'h155, 1);
        repeat (3) @(negedge clk);
        chk(10'(flag), 10'h001);
        chk(10'(pops - p0), 10'h004);
        restart();
        acc(1'b1, 10'h204, 1);
        chk(10'(flag), 10'h001);
        @(posedge clk) cnt <= 5'h04;
        repeat (3) @(negedge clk);
        wait_hi(20);
        chk(10'(hi), 10'h000);
        $display("level tests done");
        for (int m = 0; m < 2; m++) begin
            restart();
            @(posedge clk) cont <= m[0];
            acc(1'b1, 10'h234, 1);
            @(posedge clk) cnt <= 5'h04;
            wait_hi(30);
            chk(10'(hi >= 1 && hi <= 6 - 2 * m), 10'h001);
            // watch the flag while the reads run: a pulse can come and go inside them
            fork
                acc(1'b0, 10'h155, 3);
                wait_hi(50);
            join
            chk(10'(hi), 10'h000);
            fork
                acc(1'b0, 10'h155, 1);
                wait_hi(40);
            join
            chk(10'(hi >= 1 && hi <= 6 - 2 * m), 10'h001);
        end
        $display("pulse tests done");
        restart();
        acc(1'b1, 10'h264, 1);
        @(posedge clk) dm <= 1'b1;
        p0 = pops;
        o0 = oes;
        acc(1'b0, 10'h155, 2);
        chk(10'(pops - p0), 10'h002);
        chk(10'(oes - o0), 10'h008);
        acc(1'b1, 10'h0a5, 1);
        chk(control0, 10'h0a5);
        chk({1'b0, control1[8:0]}, 10'h064);
        $display("direction tests done");
        tally_and_finish();
    end
endmodule
